// [core/rcc_irq_ctrl.sv]
// Sticky event status, mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module rcc_irq_ctrl
#(
	parameter int N = 6
)
(
	input  wire logic         mclk,
	input  wire logic         resetn,
	input  wire logic [N-1:0] evt,
	input  wire logic         wr_status,
	input  wire logic         wr_mask,
	input  wire logic [N-1:0] wdata,
	output logic      [N-1:0] status_ff,
	output logic      [N-1:0] mask_ff,
	output logic              irq_ff
);
	// ****************************************
	// Sticky status, write one to clear
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			status_ff <= '0;
		else if (wr_status)
			status_ff <= (status_ff & ~wdata) | evt;
		else
			status_ff <= status_ff | evt;
	end

	// ****************************************
	// Mask register
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			mask_ff <= N'(rcc_pkg::IRQ_MASK_RESET);
		else if (wr_mask)
			mask_ff <= wdata;
	end

	// ****************************************
	// Interrupt level
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			irq_ff <= 1'b0;
		else
			irq_ff <= |(status_ff & mask_ff);
	end
endmodule
`default_nettype wire

// [core/rcc_pkg.sv]
// Constants for the reset cause control block
`default_nettype none
package rcc_pkg;
	// ****************************************
	// Bus and register map
	// ****************************************
	localparam int          ADDR_W          = 12;
	localparam int          DATA_W          = 32;
	localparam logic [11:0] OFS_CAUSE_CTRL  = 12'h000;
	localparam logic [11:0] OFS_IRQ_STATUS  = 12'h004;
	localparam logic [11:0] OFS_IRQ_MASK    = 12'h008;
	// ****************************************
	// Reset cause control bit positions
	// ****************************************
	localparam int          BIT_PRIO_EN     = 7;
	localparam int          BIT_SW_BROWNOUT = 6;
	localparam int          BIT_CFG_MISM    = 5;
	localparam int          BIT_RESET_INSTR = 4;
	localparam int          BIT_WDT_TIMEOUT = 3;
	localparam int          BIT_POWER_DOWN  = 2;
	localparam int          BIT_POWER_ON    = 1;
	localparam int          BIT_BROWNOUT    = 0;
	localparam logic [7:0]  CTRL_RESET      = 8'h7c;
	localparam logic [7:0]  CTRL_WR_MASK    = 8'hf3;
	// ****************************************
	// Interrupt status and mask layout
	// ****************************************
	localparam int          IRQ_N           = 6;
	localparam int          IRQ_CFG_MISM    = 0;
	localparam int          IRQ_RESET_INSTR = 1;
	localparam int          IRQ_WDT_TIMEOUT = 2;
	localparam int          IRQ_POWER_DOWN  = 3;
	localparam int          IRQ_BROWNOUT    = 4;
	localparam int          IRQ_WAKE        = 5;
	localparam logic [5:0]  IRQ_MASK_RESET  = 6'h00;
	// ****************************************
	// Interrupt vectors
	// ****************************************
	localparam int          PC_W            = 16;
	localparam logic [15:0] VEC_HIGH        = 16'h0008;
	localparam logic [15:0] VEC_LOW         = 16'h0018;
endpackage
`default_nettype wire

// [core/rcc_reset_cause.sv]
// Reset cause control register with APB access
//
// How it works
// - One 8-bit register tells software the last reset or wake cause.
// - Bit 7 enables two interrupt priority levels; zero means legacy mode.
// - Bit 6 is a software brown-out enable, writable, one after power-on.
// - Bit 5 reads one while no configuration mismatch reset happened.
// - Mismatch reset clears bit 5; software writes one to re-arm it.
// - Bit 4 is the reset-instruction flag, writable, one after power-on.
// - Bit 3 is the watchdog time-out flag, read-only, one after power-on.
// - Bit 2 is the power-down flag, read-only, one after power-on.
// - Bit 1 is the power-on flag, writable, zero after power-on.
// - Bit 0 is the brown-out flag, writable, zero after power-on.
// - Enabled interrupt wake loads vector 0008h or 0018h into the PC.
`timescale 1ns/1ps
`default_nettype none
module rcc_reset_cause
(
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata_ff,
	output logic             pready_ff,
	output logic             pslverr_ff,
	input  wire logic        cfg_mismatch_evt,
	input  wire logic        reset_instr_evt,
	input  wire logic        wdt_timeout_evt,
	input  wire logic        sleep_evt,
	input  wire logic        wdt_clear_evt,
	input  wire logic        brownout_evt,
	input  wire logic        wake_irq_evt,
	input  wire logic        wake_irq_high,
	input  wire logic        high_priority_global_enable,
	input  wire logic        low_priority_global_enable,
	output logic             priority_level_enable_ff,
	output logic             soft_brownout_enable_ff,
	output logic             config_mismatch_flag_ff,
	output logic             reset_instr_flag_ff,
	output logic             watchdog_timeout_flag_ff,
	output logic             power_down_flag_ff,
	output logic             power_on_flag_ff,
	output logic             brownout_reset_flag_ff,
	output logic             irq_ff,
	output logic      [15:0] vector_ff,
	output logic             vector_load_ff
);
	// ****************************************
	// Declarations
	// ****************************************
	logic                        setup;
	logic                        access;
	logic                        wr_en;
	logic                        hit_ctrl;
	logic                        hit_status;
	logic                        hit_mask;
	logic                        hit_any;
	logic                        wr_ctrl;
	logic                        wr_status;
	logic                        wr_mask;
	logic                        brownout_detect;
	logic [7:0]                  ctrl_value;
	logic [7:0]                  ctrl_wdata;
	logic [rcc_pkg::IRQ_N-1:0]   irq_evt;
	logic [rcc_pkg::IRQ_N-1:0]   irq_status;
	logic [rcc_pkg::IRQ_N-1:0]   irq_mask;
	logic [31:0]                 nxt_prdata;

	// ****************************************
	// APB decode
	// ****************************************
	assign setup      = psel && !penable;
	assign access     = psel && penable && pready_ff;
	assign wr_en      = access && pwrite;
	assign hit_ctrl   = paddr == rcc_pkg::OFS_CAUSE_CTRL;
	assign hit_status = paddr == rcc_pkg::OFS_IRQ_STATUS;
	assign hit_mask   = paddr == rcc_pkg::OFS_IRQ_MASK;
	assign hit_any    = hit_ctrl || hit_status || hit_mask;
	assign wr_ctrl    = wr_en && hit_ctrl;
	assign wr_status  = wr_en && hit_status;
	assign wr_mask    = wr_en && hit_mask;

	// ****************************************
	// Control write image
	// ****************************************
	// read-only bits keep state
	assign ctrl_wdata = (pwdata[7:0] & rcc_pkg::CTRL_WR_MASK)
	                  | (ctrl_value & ~rcc_pkg::CTRL_WR_MASK);

	// ****************************************
	// Ready, one wait-free access cycle
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			pready_ff <= 1'b0;
		else
			pready_ff <= setup;
	end

	// ****************************************
	// Error on unmapped address
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			pslverr_ff <= 1'b0;
		else
			pslverr_ff <= setup && !hit_any;
	end

	// ****************************************
	// Priority level enable
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			priority_level_enable_ff <= rcc_pkg::CTRL_RESET[rcc_pkg::BIT_PRIO_EN];
		else if (wr_ctrl)
			priority_level_enable_ff <= ctrl_wdata[rcc_pkg::BIT_PRIO_EN];
	end

	// ****************************************
	// Software brown-out enable
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			soft_brownout_enable_ff <= rcc_pkg::CTRL_RESET[rcc_pkg::BIT_SW_BROWNOUT];
		else if (wr_ctrl)
			soft_brownout_enable_ff <= ctrl_wdata[rcc_pkg::BIT_SW_BROWNOUT];
	end

	// ****************************************
	// Configuration mismatch flag
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			config_mismatch_flag_ff <= rcc_pkg::CTRL_RESET[rcc_pkg::BIT_CFG_MISM];
		else if (cfg_mismatch_evt)
			config_mismatch_flag_ff <= 1'b0;
		else if (wr_ctrl)
			config_mismatch_flag_ff <= ctrl_wdata[rcc_pkg::BIT_CFG_MISM];
	end

	// ****************************************
	// Reset instruction flag
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			reset_instr_flag_ff <= rcc_pkg::CTRL_RESET[rcc_pkg::BIT_RESET_INSTR];
		else if (reset_instr_evt)
			reset_instr_flag_ff <= 1'b0;
		else if (wr_ctrl)
			reset_instr_flag_ff <= ctrl_wdata[rcc_pkg::BIT_RESET_INSTR];
	end

	// ****************************************
	// Watchdog time-out flag
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			watchdog_timeout_flag_ff <= rcc_pkg::CTRL_RESET[rcc_pkg::BIT_WDT_TIMEOUT];
		else if (wdt_timeout_evt)
			watchdog_timeout_flag_ff <= 1'b0;
		else if (wdt_clear_evt)
			watchdog_timeout_flag_ff <= 1'b1;
	end

	// ****************************************
	// Power-down flag
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			power_down_flag_ff <= rcc_pkg::CTRL_RESET[rcc_pkg::BIT_POWER_DOWN];
		else if (sleep_evt)
			power_down_flag_ff <= 1'b0;
		else if (wdt_clear_evt)
			power_down_flag_ff <= 1'b1;
	end

	// ****************************************
	// Power-on flag
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (!resetn)
			power_on_flag_ff <= rcc_pkg::CTRL_RESET[rcc_pkg::BIT_POWER_ON];
		else if (wr_ctrl)
			power_on_flag_ff <= ctrl_wdata[rcc_pkg::BIT_POWER_ON];
	end

	// ****************************************
	// Brown-out flag
	// ****************************************
	assign brownout_detect = brownout_evt && soft_brownout_enable_ff;

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			brownout_reset_flag_ff <= rcc_pkg::CTRL_RESET[rcc_pkg::BIT_BROWNOUT];
		else if (brownout_detect)
			brownout_reset_flag_ff <= 1'b0;
		else if (wr_ctrl)
			brownout_reset_flag_ff <= ctrl_wdata[rcc_pkg::BIT_BROWNOUT];
	end

	// ****************************************
	// Register image
	// ****************************************
	// one byte of cause flags
	assign ctrl_value = {
		priority_level_enable_ff,
		soft_brownout_enable_ff,
		config_mismatch_flag_ff,
		reset_instr_flag_ff,
		watchdog_timeout_flag_ff,
		power_down_flag_ff,
		power_on_flag_ff,
		brownout_reset_flag_ff
	};

	// ****************************************
	// Read data
	// ****************************************
	always_comb
	begin
		nxt_prdata = 32'h0000_0000;
		if (hit_ctrl)
			nxt_prdata[7:0] = ctrl_value;
		else if (hit_status)
			nxt_prdata[rcc_pkg::IRQ_N-1:0] = irq_status;
		else if (hit_mask)
			nxt_prdata[rcc_pkg::IRQ_N-1:0] = irq_mask;
	end

	always_ff @(posedge mclk)
	begin
		if (!resetn)
			prdata_ff <= 32'h0000_0000;
		else if (setup && !pwrite)
			prdata_ff <= nxt_prdata;
	end

	// ****************************************
	// Interrupt events
	// ****************************************
	always_comb
	begin
		irq_evt                           = '0;
		irq_evt[rcc_pkg::IRQ_CFG_MISM]    = cfg_mismatch_evt;
		irq_evt[rcc_pkg::IRQ_RESET_INSTR] = reset_instr_evt;
		irq_evt[rcc_pkg::IRQ_WDT_TIMEOUT] = wdt_timeout_evt;
		irq_evt[rcc_pkg::IRQ_POWER_DOWN]  = sleep_evt;
		irq_evt[rcc_pkg::IRQ_BROWNOUT]    = brownout_detect;
		irq_evt[rcc_pkg::IRQ_WAKE]        = wake_irq_evt;
	end

	rcc_irq_ctrl
	#(
		.N (rcc_pkg::IRQ_N)
	)
	u_irq
	(
		.mclk      (mclk),
		.resetn    (resetn),
		.evt       (irq_evt),
		.wr_status (wr_status),
		.wr_mask   (wr_mask),
		.wdata     (pwdata[rcc_pkg::IRQ_N-1:0]),
		.status_ff (irq_status),
		.mask_ff   (irq_mask),
		.irq_ff    (irq_ff)
	);

	// ****************************************
	// Wake vector
	// ****************************************
	// vector on enabled wake
	rcc_wake_vector
	#(
		.PC_W (rcc_pkg::PC_W)
	)
	u_vec
	(
		.mclk                        (mclk),
		.resetn                      (resetn),
		.wake_irq_evt                (wake_irq_evt),
		.wake_irq_high               (wake_irq_high),
		.prio_en                     (priority_level_enable_ff),
		.high_priority_global_enable (high_priority_global_enable),
		.low_priority_global_enable  (low_priority_global_enable),
		.vector_ff                   (vector_ff),
		.vector_load_ff              (vector_load_ff)
	);

endmodule
`default_nettype wire

// [core/rcc_wake_vector.sv]
// Interrupt vector selection on wake-up
`timescale 1ns/1ps
`default_nettype none
module rcc_wake_vector
#(
	parameter int PC_W = 16
)
(
	input  wire logic            mclk,
	input  wire logic            resetn,
	input  wire logic            wake_irq_evt,
	input  wire logic            wake_irq_high,
	input  wire logic            prio_en,
	input  wire logic            high_priority_global_enable,
	input  wire logic            low_priority_global_enable,
	output logic      [PC_W-1:0] vector_ff,
	output logic                 vector_load_ff
);
	logic use_high;
	logic take;

	assign use_high = !prio_en || wake_irq_high;
	assign take     = wake_irq_evt && (use_high ? high_priority_global_enable
	                                            : low_priority_global_enable);

	// ****************************************
	// Vector load on enabled wake
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (!resetn)
		begin
			vector_ff      <= '0;
			vector_load_ff <= 1'b0;
		end
		else
		begin
			vector_load_ff <= take;
			if (take)
				vector_ff <= use_high ? PC_W'(rcc_pkg::VEC_HIGH)
				                      : PC_W'(rcc_pkg::VEC_LOW);
		end
	end
endmodule
`default_nettype wire

// [test/rcc_reset_cause_sva.sv]
// Assertion checker for the reset cause control block
`timescale 1ns/1ps
`default_nettype none
module rcc_chk
(
	input wire logic        mclk,
	input wire logic        resetn,
	input wire logic [11:0] paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] pwdata,
	input wire logic        pready_ff,
	input wire logic        pslverr_ff,
	input wire logic        cfg_mismatch_evt,
	input wire logic        wdt_timeout_evt,
	input wire logic        sleep_evt,
	input wire logic        wdt_clear_evt,
	input wire logic        wake_irq_evt,
	input wire logic        wake_irq_high,
	input wire logic        high_priority_global_enable,
	input wire logic        low_priority_global_enable,
	input wire logic        priority_level_enable_ff,
	input wire logic        soft_brownout_enable_ff,
	input wire logic        config_mismatch_flag_ff,
	input wire logic        watchdog_timeout_flag_ff,
	input wire logic        power_down_flag_ff,
	input wire logic [15:0] vector_ff,
	input wire logic        vector_load_ff
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	logic mapped;
	logic quiet;
	assign mapped = paddr == rcc_pkg::OFS_CAUSE_CTRL || paddr == rcc_pkg::OFS_IRQ_STATUS
		|| paddr == rcc_pkg::OFS_IRQ_MASK;
	assign quiet = !(wdt_timeout_evt || sleep_evt || wdt_clear_evt);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_ctl_wr;
		psel && penable && pready_ff && pwrite && paddr == rcc_pkg::OFS_CAUSE_CTRL;
	endsequence
	a_ready_after_setup: assert property (s_setup |=> pready_ff)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready_ff |=> !pready_ff)
		else $error("ready held too long");
	a_err_unmapped: assert property (s_setup ##0 !mapped |=> pslverr_ff)
		else $error("unmapped access not refused");
	a_err_mapped: assert property (s_setup ##0 mapped |=> !pslverr_ff)
		else $error("mapped access refused");
	a_rw_bits_take: assert property (s_ctl_wr |=>
		{priority_level_enable_ff, soft_brownout_enable_ff} == $past(pwdata[7:6]))
		else $error("writable bits not taken");
	a_ro_flags_keep: assert property (s_ctl_wr ##0 quiet |=>
		$stable(watchdog_timeout_flag_ff) && $stable(power_down_flag_ff))
		else $error("read-only flag changed by write");
	a_mismatch_clear: assert property (cfg_mismatch_evt |=> !config_mismatch_flag_ff)
		else $error("mismatch flag not cleared");
	a_sleep_clears_pd: assert property (sleep_evt && !wdt_clear_evt |=> !power_down_flag_ff)
		else $error("power-down flag not cleared");
	a_wdt_clear_sets: assert property (wdt_clear_evt && !sleep_evt && !wdt_timeout_evt
		|=> watchdog_timeout_flag_ff && power_down_flag_ff)
		else $error("time-out flags not set");
	a_vec_high: assert property (wake_irq_evt && high_priority_global_enable
		&& (!priority_level_enable_ff || wake_irq_high)
		|=> vector_load_ff && vector_ff == rcc_pkg::VEC_HIGH)
		else $error("high vector not loaded");
	a_vec_low: assert property (wake_irq_evt && priority_level_enable_ff && !wake_irq_high
		&& low_priority_global_enable |=> vector_load_ff && vector_ff == rcc_pkg::VEC_LOW)
		else $error("low vector not loaded");
endmodule
bind rcc_reset_cause rcc_chk rcc_chk_i (.mclk(mclk), .resetn(resetn), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready_ff(pready_ff),
	.pslverr_ff(pslverr_ff), .cfg_mismatch_evt(cfg_mismatch_evt),
	.wdt_timeout_evt(wdt_timeout_evt), .sleep_evt(sleep_evt), .wdt_clear_evt(wdt_clear_evt),
	.wake_irq_evt(wake_irq_evt), .wake_irq_high(wake_irq_high),
	.high_priority_global_enable(high_priority_global_enable),
	.low_priority_global_enable(low_priority_global_enable),
	.priority_level_enable_ff(priority_level_enable_ff),
	.soft_brownout_enable_ff(soft_brownout_enable_ff),
	.config_mismatch_flag_ff(config_mismatch_flag_ff),
	.watchdog_timeout_flag_ff(watchdog_timeout_flag_ff),
	.power_down_flag_ff(power_down_flag_ff), .vector_ff(vector_ff),
	.vector_load_ff(vector_load_ff));
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the reset cause control block
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        mclk;
	logic        resetn;
	logic [11:0] paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata_ff;
	logic        pready_ff;
	logic        pslverr_ff;
	logic [6:0]  ev;
	logic        wake_hi;
	logic        hi_en;
	logic        lo_en;
	logic [7:0]  flags;
	logic        irq_ff;
	logic [15:0] vector_ff;
	logic        vector_load_ff;
	logic [31:0] rd;
	logic        err;
	int          fails;
	int          checked;
	rcc_reset_cause rcc_reset_cause_i (.mclk(mclk), .resetn(resetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata_ff(prdata_ff), .pready_ff(pready_ff), .pslverr_ff(pslverr_ff),
		.cfg_mismatch_evt(ev[0]), .reset_instr_evt(ev[1]), .wdt_timeout_evt(ev[2]),
		.sleep_evt(ev[3]), .wdt_clear_evt(ev[4]), .brownout_evt(ev[5]),
		.wake_irq_evt(ev[6]), .wake_irq_high(wake_hi),
		.high_priority_global_enable(hi_en), .low_priority_global_enable(lo_en),
		.priority_level_enable_ff(flags[7]), .soft_brownout_enable_ff(flags[6]),
		.config_mismatch_flag_ff(flags[5]), .reset_instr_flag_ff(flags[4]),
		.watchdog_timeout_flag_ff(flags[3]), .power_down_flag_ff(flags[2]),
		.power_on_flag_ff(flags[1]), .brownout_reset_flag_ff(flags[0]),
		.irq_ff(irq_ff), .vector_ff(vector_ff), .vector_load_ff(vector_load_ff));
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		if (fails == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready_ff !== 1'b1 && n < 20);
		rd = prdata_ff;
		err = pslverr_ff;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready_ff !== 1'b1)
		begin
			fails++;
			stop_test();
		end
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic pulse(input logic [6:0] v);
		@(posedge mclk);
		ev <= v;
		@(posedge mclk);
		ev <= 7'h00;
		#1;
	endtask
	task automatic wk(input logic [2:0] c, input logic ld, input logic [15:0] v);
		@(posedge mclk);
		{wake_hi, hi_en, lo_en} <= c;
		pulse(7'h40);
		chk({31'h0, vector_load_ff}, {31'h0, ld});
		if (ld)
			chk({16'h0, vector_ff}, {16'h0, v});
	endtask
	task automatic t_reset();
		resetn <= 1'b0;
		repeat (3) @(posedge mclk);
		resetn <= 1'b1;
		chk({24'h0, flags}, 32'h7c);
		rdc(12'h000, 32'h7c);
		rdc(12'h004, 32'h00);
		rdc(12'h008, 32'h00);
	endtask
	task automatic t_write();
		apb(1'b1, 12'h000, 32'hffffffff);
		rdc(12'h000, 32'hff);
		apb(1'b1, 12'h000, 32'h0);
		rdc(12'h000, 32'h0c);
		apb(1'b1, 12'h000, 32'h80);
		rdc(12'h000, 32'h8c);
		chk({24'h0, flags}, 32'h8c);
	endtask
	task automatic t_mismatch();
		apb(1'b1, 12'h000, 32'hac);
		pulse(7'h01);
		chk({31'h0, flags[5]}, 32'h0);
		rdc(12'h000, 32'h8c);
		rdc(12'h004, 32'h01);
		apb(1'b1, 12'h004, 32'h01);
		rdc(12'h004, 32'h00);
		apb(1'b1, 12'h000, 32'hac);
		rdc(12'h000, 32'hac);
	endtask
	task automatic t_pd();
		pulse(7'h08);
		rdc(12'h000, 32'ha8);
		apb(1'b1, 12'h000, 32'hac);
		rdc(12'h000, 32'ha8);
		pulse(7'h10);
		rdc(12'h000, 32'hac);
		pulse(7'h04);
		rdc(12'h004, 32'h0c);
		apb(1'b1, 12'h004, 32'h3f);
		rdc(12'h004, 32'h00);
	endtask
	task automatic t_irq();
		apb(1'b1, 12'h008, 32'h3f);
		rdc(12'h008, 32'h3f);
		pulse(7'h20);
		rdc(12'h004, 32'h00);
		chk({31'h0, irq_ff}, 32'h0);
		apb(1'b1, 12'h000, 32'hfd);
		pulse(7'h20);
		rdc(12'h000, 32'hf4);
		rdc(12'h004, 32'h10);
		chk({31'h0, irq_ff}, 32'h1);
		apb(1'b1, 12'h008, 32'h00);
		rdc(12'h004, 32'h10);
		chk({31'h0, irq_ff}, 32'h0);
		pulse(7'h02);
		rdc(12'h000, 32'he4);
		apb(1'b1, 12'h004, 32'h12);
		rdc(12'h004, 32'h00);
		chk({31'h0, irq_ff}, 32'h0);
	endtask
	task automatic t_unmapped();
		rdc(12'h00c, 32'h0);
		chk({31'h0, err}, 32'h1);
		apb(1'b1, 12'h00c, 32'hffffffff);
		chk({31'h0, err}, 32'h1);
		rdc(12'h000, 32'he4);
		chk({31'h0, err}, 32'h0);
	endtask
	task automatic t_vector();
		apb(1'b1, 12'h000, 32'h80);
		wk(3'b001, 1'b1, 16'h0018);
		wk(3'b110, 1'b1, 16'h0008);
		wk(3'b000, 1'b0, 16'h0000);
		apb(1'b1, 12'h000, 32'h00);
		wk(3'b010, 1'b1, 16'h0008);
	endtask
	initial
	begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		ev = 7'h00;
		{wake_hi, hi_en, lo_en} = 3'b000;
		fails = 0;
		checked = 0;
		t_reset();
		t_write();
		t_mismatch();
		t_pd();
		t_irq();
		t_unmapped();
		t_vector();
		@(posedge mclk);
		t_reset();
		stop_test();
	end
endmodule
`default_nettype wire
